// ==== inc/sac_pkg.sv ====
/*
 * Shared constants of the conversion sequencer and averaging filter:
 * widths, timing counts, read thresholds and reset values.
 * Assumes a 50 MHz core clock; every timing count is derived from that rate.
 */
// Function
// - Reset on power-up or supply under 1V, then re-initialise when supply recovers.
// - Convert-start rising edge powers up the converter and starts a conversion.
// - A running conversion ignores further convert-start edges until it completes.
// - Busy stays high for the whole conversion and drops when it finishes.
// - Conversion is self-timed by the internal clock, at most 392ns.
// - After completion the converter powers down and acquires until next start.
// - Previous result can still be shifted out while powered down.
// - Conversion result register holds the latest 24-bit sample result.
// - Averaging block loads averaged results into the I/O register for serial readout.
// - Averaging supports block lengths from one to 65536 results.
// - Reading every result before the next conversion makes the filter transparent.
// - Host may stop after 20 of 24 clocks; data leaves most significant bit first.
// - Filter accumulates until a read; a read restarts the average at the next result.
// - Sum is divided by M, the next power of two at or above N.
// - 2Msps needs at least 4 averaged results and a read spread over cycles.
// - One to nineteen serial clocks between busy falls leave the I/O register unchanged.
// - First serial clock rise of a read starts it and resets the filter.

package sac_pkg;
    localparam int RES_W          = 24;
    localparam int CNT_W          = 17;
    localparam int ACC_W          = RES_W + CNT_W;
    localparam int MAX_AVG        = 65536;
    localparam int SHIFT_MAX      = 16;
    localparam int SHIFT_W        = 5;
    localparam int SCK_CNT_W      = 5;
    localparam int CONV_CNT_W     = 5;

    localparam int CLK_PERIOD_NS  = 20;
    localparam int CONV_TIME_NS   = 392;
    // Longest time, so rounded down
    localparam int CONV_CYC       = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int REINIT_TIME_US = 200;
    localparam int REINIT_CYC     = (REINIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [SCK_CNT_W-1:0] SCK_FULL_READ = 5'h14;
    localparam logic [RES_W-1:0]     IO_RST        = 24'h000000;
    localparam logic [ACC_W-1:0]     ACC_RST       = 41'h00000000000;
    localparam logic [CNT_W-1:0]     CNT_RST       = 17'h00000;
    localparam logic [CNT_W-1:0]     CNT_MAX       = 17'h1FFFF;
    localparam logic [4:0]           BIT_MSB       = 5'h17;
endpackage

// ==== design/sac_sync.sv ====
/*
 * Two flip-flop synchroniser for a group of single-bit pin inputs.
 * Assumes each bit is a level from outside the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module sac_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] din_in,
    output logic      [W-1:0] dout_out
);
    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) $error("sac_sync: width must be at least one");
    end

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q   <= '0;
            dout_out <= '0;
        end else begin
            meta_q   <= din_in;
            dout_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== design/sac_conv_avg_ctrl.sv ====
/*
 * Conversion sequencer, result register, boxcar decimator and serial
 * output register of the converter's digital core.
 * Assumes supply_low_in comes from an analog supply comparator, the pins
 * are asynchronous, and core_result_in is stable when busy falls.
 */
`timescale 1ns/1ps
`default_nettype none

module sac_conv_avg_ctrl
    import sac_pkg::*;
#(
    parameter int REINIT_CYCLES = sac_pkg::REINIT_CYC
) (
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      supply_low_in,
    input  wire logic                      convert_start_in,
    input  wire logic                      sck_in,
    input  wire logic [sac_pkg::RES_W-1:0] core_result_in,
    output logic                           busy_out,
    output logic                           sdo_out,
    output logic                           power_up_out,
    output logic                           acquire_out,
    output logic                           ready_out
);
    import sac_pkg::*;

    initial begin
        if (REINIT_CYCLES < 1 || REINIT_CYCLES > 1000000)
            $error("sac_conv_avg_ctrl: REINIT_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection

    logic [2:0] pins_s;
    logic       supply_low_s;
    logic       cnv_s;
    logic       sck_s;
    logic       cnv_d1_q;
    logic       sck_d1_q;

    sac_sync #(.W(3)) u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .din_in      ({supply_low_in, convert_start_in, sck_in}),
        .dout_out    (pins_s)
    );

    assign supply_low_s = pins_s[2];
    assign cnv_s        = pins_s[1];
    assign sck_s        = pins_s[0];

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnv_d1_q <= 1'b0;
            sck_d1_q <= 1'b0;
        end else begin
            cnv_d1_q <= cnv_s;
            sck_d1_q <= sck_s;
        end
    end

    wire cnv_rise = cnv_s & ~cnv_d1_q;
    wire sck_rise = sck_s & ~sck_d1_q;

    ////////////////////////////////////////////////////////////////////
    // Power-on reset and re-initialisation wait

    logic [19:0] reinit_cnt_q;
    logic        ready_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reinit_cnt_q <= 20'(REINIT_CYCLES);
            ready_q      <= 1'b0;
        end else if (supply_low_s) begin
            reinit_cnt_q <= 20'(REINIT_CYCLES);
            ready_q      <= 1'b0;
        end else if (reinit_cnt_q != 20'h00000) begin
            reinit_cnt_q <= reinit_cnt_q - 20'h00001;
            ready_q      <= (reinit_cnt_q == 20'h00001);
        end
    end

    // Whole core held while supply is low or re-initialising
    wire soft_rst = supply_low_s | ~ready_q;

    ////////////////////////////////////////////////////////////////////
    // Conversion sequencing on the internal clock

    logic                  busy_q;
    logic [CONV_CNT_W-1:0] conv_cnt_q;
    logic [RES_W-1:0]      result_q;

    wire conv_start = cnv_rise & ~busy_q & ~soft_rst;
    wire conv_done  = busy_q & (conv_cnt_q == CONV_CNT_W'(1));

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q     <= 1'b0;
            conv_cnt_q <= '0;
        end else if (soft_rst) begin
            busy_q     <= 1'b0;
            conv_cnt_q <= '0;
        end else if (conv_start) begin
            busy_q     <= 1'b1;
            conv_cnt_q <= CONV_CNT_W'(CONV_CYC);
        end else if (busy_q) begin
            busy_q     <= ~conv_done;
            conv_cnt_q <= conv_cnt_q - CONV_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            result_q <= IO_RST;
        else if (soft_rst)
            result_q <= IO_RST;
        else if (conv_done)
            result_q <= core_result_in;
    end

    ////////////////////////////////////////////////////////////////////
    // Read tracking: serial clocks counted between busy falls

    logic                 read_act_q;
    logic [SCK_CNT_W-1:0] sck_cyc_q;

    wire rd_start = sck_rise & ~read_act_q;
    // Partial counts let one read span several conversions
    wire upd_ok   = (sck_cyc_q == '0) | (sck_cyc_q >= SCK_FULL_READ);
    wire io_load  = conv_done & upd_ok;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_cyc_q <= '0;
        end else if (soft_rst) begin
            sck_cyc_q <= '0;
        end else if (conv_done) begin
            sck_cyc_q <= SCK_CNT_W'(sck_rise);
        end else if (sck_rise && sck_cyc_q < SCK_FULL_READ) begin
            sck_cyc_q <= sck_cyc_q + SCK_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            read_act_q <= 1'b0;
        else if (soft_rst)
            read_act_q <= 1'b0;
        else if (rd_start)
            read_act_q <= 1'b1;
        else if (io_load)
            read_act_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Boxcar decimator: accumulate, then scale by next power of two

    logic [ACC_W-1:0] acc_q;
    logic [CNT_W-1:0] n_q;

    function automatic logic [SHIFT_W-1:0] avg_shift(input logic [CNT_W-1:0] n);
        logic [SHIFT_W-1:0] s;
        s = '0;
        for (int i = 0; i < SHIFT_MAX; i++) begin
            if ((CNT_W'(1) << i) < n) s = SHIFT_W'(i + 1);
        end
        return s;
    endfunction

    wire [ACC_W-1:0]   res_ext  = {{CNT_W{core_result_in[RES_W-1]}}, core_result_in};
    wire [ACC_W-1:0]   new_sum  = acc_q + res_ext;
    wire [CNT_W-1:0]   n_next   = (n_q == CNT_MAX) ? n_q : n_q + CNT_W'(1);
    wire [SHIFT_W-1:0] shift_w  = avg_shift(n_next);
    wire [ACC_W-1:0]   avg_full = ACC_W'($signed(new_sum) >>> shift_w);
    // Beyond 65536 results the gain exceeds one, so clamp
    wire               sat_ok   = (&avg_full[ACC_W-1:RES_W-1]) | ~(|avg_full[ACC_W-1:RES_W-1]);
    wire [RES_W-1:0]   avg_res  = sat_ok ? avg_full[RES_W-1:0]
                                         : {avg_full[ACC_W-1], {(RES_W-1){~avg_full[ACC_W-1]}}};

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q <= ACC_RST;
            n_q   <= CNT_RST;
        end else if (soft_rst) begin
            acc_q <= ACC_RST;
            n_q   <= CNT_RST;
        end else if (rd_start) begin
            acc_q <= conv_done ? res_ext : ACC_RST;
            n_q   <= conv_done ? CNT_W'(1) : CNT_RST;
        end else if (conv_done) begin
            acc_q <= new_sum;
            n_q   <= n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // I/O register and serial shift-out, MSB first

    logic [RES_W-1:0] io_q;
    logic [4:0]       bit_idx_q;
    logic             sdo_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            io_q <= IO_RST;
        else if (soft_rst)
            io_q <= IO_RST;
        else if (io_load)
            io_q <= avg_res;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            bit_idx_q <= BIT_MSB;
        else if (soft_rst || io_load)
            bit_idx_q <= BIT_MSB;
        else if (sck_rise && bit_idx_q != 5'h00)
            bit_idx_q <= bit_idx_q - 5'h01;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            sdo_q <= 1'b0;
        else
            sdo_q <= io_q[bit_idx_q];
    end

    assign busy_out     = busy_q;
    assign sdo_out      = sdo_q;
    assign power_up_out = busy_q;
    assign acquire_out  = ready_q & ~busy_q;
    assign ready_out    = ready_q;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Nineteen busy cycles in all, split to keep each repetition short
    sequence conv_run_s;
        busy_q [*8] ##1 busy_q [*8] ##1 busy_q [*3];
    endsequence

    sequence conv_end_s;
        ##1 !busy_q ##0 acquire_out;
    endsequence

    property conv_len_p;
        (conv_start ##1 busy_q) |-> conv_run_s ##1 (!busy_q || soft_rst);
    endproperty

    busy_span_a:     assert property (conv_start && !supply_low_s |=> busy_q && conv_cnt_q == 5'h13)
                         else $error("busy not raised with full count");
    conv_len_a:      assert property (conv_len_p)
                         else $error("conversion length wrong");
    no_restart_a:    assert property (busy_q && cnv_rise && !conv_done && !soft_rst
                                      |=> busy_q && conv_cnt_q == $past(conv_cnt_q) - 5'h01)
                         else $error("conversion restarted while busy");
    start_pwr_a:     assert property (cnv_rise && !busy_q && !soft_rst |=> power_up_out && !acquire_out)
                         else $error("start did not power up");
    auto_down_a:     assert property (conv_done && !soft_rst |-> conv_end_s)
                         else $error("no power-down after conversion");
    por_hold_a:      assert property (supply_low_s |=> !ready_out ##1 !busy_q [*3])
                         else $error("core ran during supply drop");
    result_reg_a:    assert property (conv_done && !soft_rst |=> result_q == $past(core_result_in))
                         else $error("result register not loaded");
    transparent_a:   assert property (conv_done && upd_ok && n_q == CNT_RST && !rd_start && !soft_rst
                                      |=> io_q == $past(core_result_in))
                         else $error("single result not passed through");
    partial_hold_a:  assert property (conv_done && sck_cyc_q > 5'h00 && sck_cyc_q < 5'h14 && !soft_rst
                                      |=> $stable(io_q))
                         else $error("I/O register changed mid-read");
    read_reset_a:    assert property (rd_start && !conv_done && !soft_rst
                                      |=> n_q == CNT_RST && acc_q == ACC_RST && read_act_q)
                         else $error("filter not reset at read start");
    accumulate_a:    assert property (conv_done && !rd_start && !soft_rst && n_q < CNT_MAX
                                      |=> n_q == $past(n_q) + 17'h00001)
                         else $error("result not accumulated");
    scale_three_a:   assert property (io_load && n_q == 17'h00002 && !rd_start && !soft_rst
                                      |=> io_q == $past(new_sum[RES_W+1:2]))
                         else $error("three results not scaled by four");
    msb_first_a:     assert property (io_load && !soft_rst ##1 !sck_rise [*2]
                                      |=> sdo_out == io_q[RES_W-1])
                         else $error("first bit out is not the MSB");
endmodule
`default_nettype wire

// ==== tb/sac_host_model.sv ====
/*
 * Behavioural host for the converter core: convert-start pulses, a
 * 160 ns serial clock and sampling of serial data.
 * Assumes the bench calls one task at a time, off the core clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sac_host_model (
    input  wire logic busy_in,
    input  wire logic sdo_in,
    output logic      convert_start_out,
    output logic      sck_out
);
    localparam int SCK_HALF_NS = 80;
    localparam int ACQ_NS      = 100;

    initial begin
        convert_start_out = 1'b0;
        sck_out           = 1'b0;
    end

    // Bounded poll; a stuck busy is left to the bench conversion count check
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 200 && busy_in !== lvl; i++) begin
            #5;
        end
    endtask

    // Extra edge stays inside the first 40 ns yet spans one core edge
    // when started 7 ns after it, so the core sees a second rise
    task automatic convert(input bit restart);
        convert_start_out = 1'b1;
        if (restart) begin
            #20 convert_start_out = 1'b0;
            #18 convert_start_out = 1'b1;
        end
        wait_busy(1'b1);
        wait_busy(1'b0);
        convert_start_out = 1'b0;
        #ACQ_NS;
    endtask

    // Samples before each rise, well after the last rise moved data
    task automatic read(input int n, output logic [23:0] data);
        data = 24'h000000;
        for (int k = 0; k < n; k++) begin
            #SCK_HALF_NS;
            data = {data[22:0], sdo_in};
            sck_out = 1'b1;
            #SCK_HALF_NS sck_out = 1'b0;
        end
        #SCK_HALF_NS;
    endtask
endmodule

`default_nettype wire

// ==== tb/sac_conv_avg_ctrl_tb_top.sv ====
/*
 * Self-checking bench for the conversion sequencer and averaging filter.
 * Assumes a 50 MHz core clock and a short re-initialisation wait.
 */
`timescale 1ns/1ps
`default_nettype none

module sac_conv_avg_ctrl_tb_top;
    import sac_pkg::*;
    localparam int REINIT_SIM = 20;

    logic             core_clk_in    = 1'b0;
    logic             rst_n_in       = 1'b0;
    logic             supply_low_in  = 1'b0;
    logic [RES_W-1:0] core_result_in = 24'h000000;
    wire              busy_out, sdo_out, power_up_out, acquire_out, ready_out;
    wire              convert_start, sck;
    integer           seed = 32'hEDC5D740;
    int               n_fail, num_checks, busy_len, n_conv, exp_conv;
    logic [23:0]      hist[$];

    sac_conv_avg_ctrl #(.REINIT_CYCLES(REINIT_SIM)) sac_conv_avg_ctrl_inst (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .supply_low_in(supply_low_in),
        .convert_start_in(convert_start), .sck_in(sck), .core_result_in(core_result_in),
        .busy_out(busy_out), .sdo_out(sdo_out), .power_up_out(power_up_out),
        .acquire_out(acquire_out), .ready_out(ready_out));

    sac_host_model sac_host_model_inst (
        .busy_in(busy_out), .sdo_in(sdo_out), .convert_start_out(convert_start), .sck_out(sck));

    always #10 core_clk_in = ~core_clk_in;

    ////////////////////////////////////////
    task automatic chk(input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Sum over M, the power of two at or above N
    function automatic logic [23:0] avg_of(input logic [23:0] q[$]);
        logic signed [40:0] sum;
        int m;
        sum = '0;
        m = 0;
        foreach (q[i]) sum += $signed(q[i]);
        while ((1 << m) < q.size()) m++;
        return 24'(sum >>> m);
    endfunction

    task automatic conv(input logic [23:0] r, input bit restart);
        @(posedge core_clk_in);
        core_result_in <= r;
        #7;
        sac_host_model_inst.convert(restart);
        hist.push_back(r);
        exp_conv++;
    endtask

    task automatic rd(input int n, input logic [23:0] exp);
        logic [23:0] d;
        @(posedge core_clk_in);
        #7;
        sac_host_model_inst.read(n, d);
        chk(exp >> (24 - n), d);
    endtask

    // Sampled 1 ns after each edge, so cycles count exactly
    task automatic wait_ready(input int exp_cyc);
        int cyc;
        cyc = 0;
        while (ready_out !== 1'b1 && cyc < 200) begin
            @(posedge core_clk_in);
            #1;
            cyc++;
        end
        chk(24'h1, {23'h0, ready_out === 1'b1});
        chk(24'(exp_cyc), 24'(cyc));
    endtask

    ////////////////////////////////////////
    always @(posedge core_clk_in) begin
        if (busy_out === 1'b1) begin
            if (busy_len == 0) n_conv++;
            if (busy_len == 1) chk(24'h2, {22'h0, power_up_out, acquire_out});
            busy_len++;
        end else if (busy_len != 0) begin
            chk(24'(CONV_CYC), 24'(busy_len));
            chk(24'h1, {22'h0, power_up_out, acquire_out});
            busy_len = 0;
        end
    end

    initial begin
        // Full run needs about 4000 cycles
        repeat (20000) @(posedge core_clk_in);
        n_fail++;
        final_report();
    end

    initial begin
        logic [23:0] e, d, part;
        repeat (5) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        chk(24'h0, {23'h0, ready_out});
        wait_ready(REINIT_SIM - 1);
        rd(20, 24'h000000);
        for (int i = 0; i < 8; i++) begin
            e = (i == 0) ? 24'h7FFFFF : (i == 1) ? 24'h800000 : 24'($random(seed));
            conv(e, i == 2);
            rd((i % 2) ? 20 : 24, e);
        end
        // Supply dip after real data; two sync stages delay the restart
        @(posedge core_clk_in);
        supply_low_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        supply_low_in <= 1'b0;
        @(posedge core_clk_in);
        chk(24'h0, {23'h0, ready_out});
        wait_ready(REINIT_SIM + 1);
        rd(20, 24'h000000);
        for (int n = 2; n <= 5; n++) begin
            hist.delete();
            for (int k = 0; k < n; k++) conv(24'($random(seed)), 1'b0);
            rd(24, avg_of(hist));
        end
        // Distributed read of a 4-average, 8 clocks per cycle
        hist.delete();
        for (int k = 0; k < 4; k++) conv(24'($random(seed)), 1'b0);
        e = avg_of(hist);
        hist.delete();
        d = 24'h000000;
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk_in);
            #7;
            sac_host_model_inst.read(8, part);
            d = {d[15:0], part[7:0]};
            conv(24'($random(seed)), 1'b0);
        end
        conv(24'($random(seed)), 1'b0);
        chk(e, d);
        rd(24, avg_of(hist));
        chk(24'(exp_conv), 24'(n_conv));
        final_report();
    end
endmodule

`default_nettype wire
